// ==== hw/exec_pkg.sv ====
package exec_pkg;
   // Register byte offsets on the bus.
   localparam logic [7:0] OFS_INSTR = 8'h00;
   localparam logic [7:0] OFS_CTRL = 8'h04;
   localparam logic [7:0] OFS_STAT = 8'h08;
   localparam logic [7:0] OFS_FLAGS = 8'h0c;
   localparam logic [7:0] OFS_ACCUM = 8'h10;
   localparam logic [7:0] OFS_BANK = 8'h14;
   localparam logic [7:0] OFS_PROD = 8'h18;
   localparam logic [7:0] OFS_FSR0 = 8'h1c;
   localparam logic [7:0] OFS_FSR1 = 8'h20;
   localparam logic [7:0] OFS_FSR2 = 8'h24;
   localparam logic [7:0] OFS_CYCLES = 8'h28;
   // Field positions.
   localparam int CTRL_EXT_BIT = 0;
   localparam int FLG_C = 0;
   localparam int FLG_DC = 1;
   localparam int FLG_Z = 2;
   localparam int FLG_OV = 3;
   localparam int FLG_N = 4;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_WAIT_BIT = 1;
   localparam int STAT_UNSUP_BIT = 2;
   localparam int STAT_PH_LSB = 4;
   // Reset values.
   localparam logic [7:0] ACCUM_RST = 8'h00;
   localparam logic [7:0] BANK_RST = 8'h00;
   localparam logic [4:0] FLAGS_RST = 5'h00;
   localparam logic CTRL_EXT_RST = 1'b0;
   localparam logic [11:0] FSR_RST = 12'h000;
   // Data space layout.
   localparam logic [11:0] ACCUM_ADDR = 12'hf00;
   localparam logic [7:0] ACCESS_SPLIT = 8'h60;
   localparam logic [7:0] INDEX_LIMIT = 8'h5f;
   localparam logic [3:0] ACCESS_HI_BANK = 4'hf;
   localparam logic [7:0] SIGN_MIN = 8'h80;
   // Quarter phases of one instruction cycle.
   localparam logic [1:0] PH_Q1 = 2'h0;
   localparam logic [1:0] PH_Q2 = 2'h1;
   localparam logic [1:0] PH_Q3 = 2'h2;
   localparam logic [1:0] PH_Q4 = 2'h3;
   // Opcode fields.
   localparam logic [15:0] WORD_ZERO = 16'h0000;
   localparam logic [5:0] ENC_FILE_MOVE = 6'h14;
   localparam logic [7:0] ENC_BANK = 8'h01;
   localparam logic [7:0] ENC_LITW = 8'h0e;
   localparam logic [7:0] ENC_MULL = 8'h0d;
   localparam logic [6:0] ENC_STORE = 7'h37;
   localparam logic [6:0] ENC_MULF = 7'h01;
   localparam logic [6:0] ENC_NEG = 7'h36;
   localparam logic [3:0] ENC_FF = 4'hc;
   localparam logic [3:0] ENC_SECOND = 4'hf;
   localparam logic [9:0] ENC_POINTER_LOAD = 10'h3b8;

   typedef enum logic [3:0] {
      OP_NOP = 4'b0000, OP_FILE_MOVE = 4'b0001, OP_BANK = 4'b0010, OP_LITW = 4'b0011,
      OP_STORE = 4'b0100, OP_MULL = 4'b0101, OP_MULF = 4'b0110, OP_NEG = 4'b0111,
      OP_FF1 = 4'b1000, OP_FF2 = 4'b1001, OP_LF1 = 4'b1010, OP_LF2 = 4'b1011,
      OP_NONE = 4'b1100
   } op_e;

   typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_EXEC = 2'b01, ST_WAIT2 = 2'b10} exec_state_e;

   // Maps a first instruction word onto the operation it starts.
   function automatic op_e decode_op(input logic [15:0] w);
      if (w == WORD_ZERO || w[15:12] == ENC_SECOND) return OP_NOP;
      if (w[15:10] == ENC_FILE_MOVE) return OP_FILE_MOVE;
      if (w[15:8] == ENC_BANK) return OP_BANK;
      if (w[15:8] == ENC_LITW) return OP_LITW;
      if (w[15:8] == ENC_MULL) return OP_MULL;
      if (w[15:9] == ENC_STORE) return OP_STORE;
      if (w[15:9] == ENC_MULF) return OP_MULF;
      if (w[15:9] == ENC_NEG) return OP_NEG;
      if (w[15:12] == ENC_FF) return OP_FF1;
      if (w[15:6] == ENC_POINTER_LOAD) return OP_LF1;
      return OP_NONE;
   endfunction

   // Forms the 12-bit data address of a one-word file operand.
   function automatic logic [11:0] file_addr(input logic a, input logic [7:0] f, input logic [7:0] bank,
                                             input logic ext, input logic [11:0] base);
      if (a) return {bank[3:0], f};
      if (ext && f <= INDEX_LIMIT) return base + {4'h0, f};
      if (f < ACCESS_SPLIT) return {4'h0, f};
      return {ACCESS_HI_BANK, f};
   endfunction
endpackage

// ==== hw/exec_alu.sv ====
`timescale 1ns/1ns
module exec_alu
   import exec_pkg::*;
(
   input op_e op, // Operation in progress.
   input logic [7:0] opnd, // File value or literal.
   input logic [7:0] accum, // Working register.
   input logic [4:0] flags_in, // Current status flags.
   output logic [7:0] res, // Result byte.
   output logic [4:0] flags_out, // Flags after the operation.
   output logic [15:0] prod // Unsigned product.
);
   // The product is formed for every operation; only multiplies keep it.
   assign prod = 16'(accum) * 16'(opnd);

   // Result and flag logic, flags pass through unless the operation sets them.
   always_comb begin
      res = opnd;
      flags_out = flags_in;
      case (op)
         OP_FILE_MOVE: begin
            flags_out[FLG_N] = opnd[7];
            flags_out[FLG_Z] = (opnd == 8'h00);
         end
         OP_BANK: begin
            res = {4'h0, opnd[3:0]};
         end
         OP_STORE: begin
            res = accum;
         end
         OP_NEG: begin
            res = (~opnd) + 8'h01;
            flags_out[FLG_C] = (opnd == 8'h00);
            flags_out[FLG_DC] = (opnd[3:0] == 4'h0);
            flags_out[FLG_OV] = (opnd == SIGN_MIN);
            flags_out[FLG_N] = res[7];
            flags_out[FLG_Z] = (res == 8'h00);
         end
         default: begin
            res = opnd;
         end
      endcase
   end
endmodule

// ==== hw/byte_move_multiply_exec.sv ====
`timescale 1ns/1ns
// Notes on behaviour
// - File move copies file to accumulator or back to file, setting negative and zero.
// - Access bit low uses the access bank, high uses the bank select register.
// - Extended set with access bit low and f at most 5Fh uses indexed offset.
// - The 8-bit file operand reaches any byte of the selected 256-byte bank.
// - Two-word move copies any 12-bit source to any 12-bit destination, no flags.
// - The accumulator may be source or destination of the two-word move.
// - Two-word move takes two cycles, reading in the first, writing in the second.
// - Bank literal load keeps the low nibble and forces the upper nibble zero.
// - Literal load places the literal in the accumulator, flags untouched.
// - Store writes the accumulator into the addressed file, flags untouched.
// - Literal multiply writes the unsigned product into product high and low.
// - File multiply writes the unsigned product, leaving both operands unchanged.
// - Multiplies change no flag, not even for a zero product.
// - Negate replaces the file with its two's complement, setting five flags.
// - Pointer load writes the high nibble in cycle one, low byte in cycle two.
module byte_move_multiply_exec
   import exec_pkg::*;
(
   input logic hclk, // Core clock.
   input logic hresetn, // Asynchronous reset, active low.
   input logic hsel, // Slave select.
   input logic [31:0] haddr, // Byte address.
   input logic [1:0] htrans, // Transfer type.
   input logic hwrite, // Write when high.
   input logic [2:0] hsize, // Transfer size, words only.
   input logic [31:0] hwdata, // Write data.
   input logic hready, // Bus ready.
   output logic [31:0] hrdata, // Read data.
   output logic hreadyout, // Slave ready.
   output logic hresp, // Always OKAY.
   output logic [11:0] dm_addr, // Data memory address.
   output logic dm_re, // Data memory read strobe.
   input logic [7:0] dm_rdata, // Read data, one cycle after the strobe.
   output logic dm_we, // Data memory write strobe.
   output logic [7:0] dm_wdata // Data memory write data.
);
   logic ap_valid_q, ap_write_q, ap_hit_q, wr_fire, instr_wr, unsup_q, ctrl_ext_q, dm_we_q;
   logic in_exec, q3, q4, lit_op, src_accum, dst_accum, need_read, file_wr;
   logic [7:0] ap_addr_q, accum_q, bank_q, dm_wdata_q, res_q, move_q, opnd, alu_res;
   logic [31:0] hrdata_q;
   exec_state_e st_q;
   logic [1:0] ph_q, fsr_idx;
   op_e op_q, op_new;
   logic [15:0] ir_q, w2_q, prod_q, cycles_q, prod_res_q, alu_prod;
   logic [4:0] flags_q, flg_res_q, alu_flags;
   logic [11:0] fsr_q [3];
   logic [11:0] addr_q;

   // Bus address phase capture; only a selected non-idle transfer is kept.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ap_valid_q <= 1'b0;
         ap_write_q <= 1'b0;
         ap_hit_q <= 1'b0;
         ap_addr_q <= 8'h00;
      end else if (hready) begin
         ap_valid_q <= hsel && htrans[1];
         ap_write_q <= hwrite;
         ap_hit_q <= (haddr[31:8] == 24'h000000);
         ap_addr_q <= haddr[7:0];
      end
   end

   // A new instruction word waits while the previous cycle is still running.
   assign hreadyout = !(ap_valid_q && ap_write_q && ap_hit_q && ap_addr_q == OFS_INSTR && st_q == ST_EXEC);
   assign hresp = 1'b0;
   assign wr_fire = ap_valid_q && ap_write_q && ap_hit_q && hreadyout;
   assign instr_wr = wr_fire && ap_addr_q == OFS_INSTR;
   assign hrdata = hrdata_q;

   // Read data is taken in the address phase; unmapped words read as zero.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_q <= 32'h00000000;
      end else if (hready && hsel && htrans[1] && !hwrite) begin
         hrdata_q <= 32'h00000000;
         if (haddr[31:8] == 24'h000000) begin
            case (haddr[7:0])
               OFS_INSTR: hrdata_q <= {w2_q, ir_q};
               OFS_CTRL: hrdata_q[CTRL_EXT_BIT] <= ctrl_ext_q;
               OFS_STAT: begin
                  hrdata_q[STAT_BUSY_BIT] <= in_exec;
                  hrdata_q[STAT_WAIT_BIT] <= (st_q == ST_WAIT2);
                  hrdata_q[STAT_UNSUP_BIT] <= unsup_q;
                  hrdata_q[STAT_PH_LSB +: 2] <= ph_q;
               end
               OFS_FLAGS: hrdata_q[4:0] <= flags_q;
               OFS_ACCUM: hrdata_q[7:0] <= accum_q;
               OFS_BANK: hrdata_q[7:0] <= bank_q;
               OFS_PROD: hrdata_q[15:0] <= prod_q;
               OFS_FSR0: hrdata_q[11:0] <= fsr_q[0];
               OFS_FSR1: hrdata_q[11:0] <= fsr_q[1];
               OFS_FSR2: hrdata_q[11:0] <= fsr_q[2];
               OFS_CYCLES: hrdata_q[15:0] <= cycles_q;
               default: hrdata_q <= 32'h00000000;
            endcase
         end
      end
   end

   // Extended instruction set enable.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_ext_q <= CTRL_EXT_RST;
      end else if (wr_fire && ap_addr_q == OFS_CTRL) begin
         ctrl_ext_q <= hwdata[CTRL_EXT_BIT];
      end
   end

   // Phase decoding of the running instruction cycle.
   assign in_exec = (st_q == ST_EXEC);
   assign q3 = in_exec && ph_q == PH_Q3;
   assign q4 = in_exec && ph_q == PH_Q4;
   assign op_new = decode_op(hwdata[15:0]);
   assign fsr_idx = ir_q[5:4];

   // Sequencer: four quarter phases per cycle, two-word operations wait for word two.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_q <= ST_IDLE;
         ph_q <= PH_Q1;
      end else begin
         case (st_q)
            ST_IDLE: begin
               if (instr_wr) begin
                  st_q <= ST_EXEC;
                  ph_q <= PH_Q1;
               end
            end
            ST_EXEC: begin
               ph_q <= ph_q + 2'h1;
               if (ph_q == PH_Q4) begin
                  st_q <= (op_q == OP_FF1 || op_q == OP_LF1) ? ST_WAIT2 : ST_IDLE;
               end
            end
            ST_WAIT2: begin
               if (instr_wr) begin
                  st_q <= ST_EXEC;
                  ph_q <= PH_Q1;
               end
            end
            default: begin
               st_q <= ST_IDLE;
               ph_q <= PH_Q1;
            end
         endcase
      end
   end

   // Instruction words and the decoded operation.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ir_q <= WORD_ZERO;
         w2_q <= WORD_ZERO;
         op_q <= OP_NOP;
         unsup_q <= 1'b0;
      end else if (instr_wr && st_q == ST_IDLE) begin
         ir_q <= hwdata[15:0];
         op_q <= op_new;
         unsup_q <= (op_new == OP_NONE);
      end else if (instr_wr && st_q == ST_WAIT2) begin
         w2_q <= hwdata[15:0];
         op_q <= (op_q == OP_FF1) ? OP_FF2 : OP_LF2;
      end
   end

   // Q1 forms the data address of the cycle.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         addr_q <= 12'h000;
      end else if (in_exec && ph_q == PH_Q1) begin
         case (op_q)
            OP_FF1: addr_q <= ir_q[11:0];
            OP_FF2: addr_q <= w2_q[11:0];
            default: addr_q <= file_addr(ir_q[8], ir_q[7:0], bank_q, ctrl_ext_q, fsr_q[2]);
         endcase
      end
   end

   // Operand source and destination selection.
   assign lit_op = (op_q == OP_BANK || op_q == OP_LITW || op_q == OP_MULL);
   assign src_accum = (op_q == OP_FF1 && addr_q == ACCUM_ADDR);
   assign dst_accum = (op_q == OP_FF2 && addr_q == ACCUM_ADDR);
   assign need_read = (op_q == OP_FILE_MOVE || op_q == OP_MULF || op_q == OP_NEG || (op_q == OP_FF1 && !src_accum));
   assign file_wr = (op_q == OP_FILE_MOVE && ir_q[9]) || op_q == OP_STORE || op_q == OP_NEG ||
                    (op_q == OP_FF2 && !dst_accum);
   assign opnd = lit_op ? ir_q[7:0] : (src_accum ? accum_q : dm_rdata);

   // Data memory strobes: reads only in Q2, writes only in Q4.
   assign dm_addr = addr_q;
   assign dm_re = in_exec && ph_q == PH_Q2 && need_read;
   assign dm_we = dm_we_q;
   assign dm_wdata = dm_wdata_q;

   exec_alu exec_alu_i (
      .op(op_q),
      .opnd(opnd),
      .accum(accum_q),
      .flags_in(flags_q),
      .res(alu_res),
      .flags_out(alu_flags),
      .prod(alu_prod)
   );

   // Q3 processes the operand and stages every result for Q4.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         res_q <= 8'h00;
         move_q <= 8'h00;
         flg_res_q <= FLAGS_RST;
         prod_res_q <= 16'h0000;
      end else if (q3) begin
         res_q <= (op_q == OP_FF2) ? move_q : alu_res;
         flg_res_q <= alu_flags;
         prod_res_q <= alu_prod;
         if (op_q == OP_FF1) begin
            move_q <= opnd;
         end
      end
   end

   // The file write stands for the whole of Q4.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dm_we_q <= 1'b0;
         dm_wdata_q <= 8'h00;
      end else if (q3) begin
         dm_we_q <= file_wr;
         dm_wdata_q <= (op_q == OP_FF2) ? move_q : alu_res;
      end else begin
         dm_we_q <= 1'b0;
      end
   end

   // Accumulator: Q4 result wins over a bus write in the same cycle.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         accum_q <= ACCUM_RST;
      end else if (q4 && ((op_q == OP_FILE_MOVE && !ir_q[9]) || op_q == OP_LITW || dst_accum)) begin
         accum_q <= res_q;
      end else if (wr_fire && ap_addr_q == OFS_ACCUM) begin
         accum_q <= hwdata[7:0];
      end
   end

   // Bank select register, upper nibble always zero.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bank_q <= BANK_RST;
      end else if (q4 && op_q == OP_BANK) begin
         bank_q <= res_q;
      end else if (wr_fire && ap_addr_q == OFS_BANK) begin
         bank_q <= {4'h0, hwdata[3:0]};
      end
   end

   // Status flags change only for file move, negate and a bus write to the flags register.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         flags_q <= FLAGS_RST;
      end else if (q4 && (op_q == OP_FILE_MOVE || op_q == OP_NEG)) begin
         flags_q <= flg_res_q;
      end else if (wr_fire && ap_addr_q == OFS_FLAGS) begin
         flags_q <= hwdata[4:0];
      end
   end

   // Product pair.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         prod_q <= 16'h0000;
      end else if (q4 && (op_q == OP_MULL || op_q == OP_MULF)) begin
         prod_q <= prod_res_q;
      end
   end

   // File select pointers; index three names no pointer and is dropped.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fsr_q[0] <= FSR_RST;
         fsr_q[1] <= FSR_RST;
         fsr_q[2] <= FSR_RST;
      end else if (q4 && op_q == OP_LF1 && fsr_idx != 2'h3) begin
         fsr_q[fsr_idx][11:8] <= ir_q[3:0];
      end else if (q4 && op_q == OP_LF2 && fsr_idx != 2'h3) begin
         fsr_q[fsr_idx][7:0] <= w2_q[7:0];
      end
   end

   // Instruction cycles executed since reset.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cycles_q <= 16'h0000;
      end else if (q4) begin
         cycles_q <= cycles_q + 16'h0001;
      end
   end

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   // Bank register upper nibble never leaves zero.
   property p_bank_upper;
      bank_q[7:4] == 4'h0;
   endproperty
   a_bank_upper: assert property (p_bank_upper) else $error("bank upper nibble not zero");
   // Literal load lands in the accumulator with flags held.
   property p_lit_accum;
      (q4 && op_q == OP_LITW) |=> (accum_q == $past(ir_q[7:0])) && $stable(flags_q);
   endproperty
   a_lit_accum: assert property (p_lit_accum) else $error("literal load wrong");
   // Literal multiply product.
   property p_mul_prod;
      (q4 && op_q == OP_MULL) |=> prod_q == 16'($past(accum_q)) * 16'($past(ir_q[7:0]));
   endproperty
   a_mul_prod: assert property (p_mul_prod) else $error("literal product wrong");
   // Multiplies keep flags and accumulator and never write the file.
   property p_mul_keep;
      (q4 && (op_q == OP_MULL || op_q == OP_MULF)) |-> !dm_we ##1 ($stable(flags_q) && $stable(accum_q));
   endproperty
   a_mul_keep: assert property (p_mul_keep) else $error("multiply changed state");
   // Store drives the accumulator onto the file write in Q4.
   property p_store;
      (q4 && op_q == OP_STORE) |-> dm_we && dm_wdata == accum_q;
   endproperty
   a_store: assert property (p_store) else $error("store write wrong");
   // Reads happen only in Q2.
   property p_read_q2;
      dm_re |-> in_exec && ph_q == PH_Q2;
   endproperty
   a_read_q2: assert property (p_read_q2) else $error("read outside Q2");
   // An instruction cycle lasts exactly four clocks.
   property p_four_phases;
      $rose(in_exec) |-> in_exec [*4] ##1 !in_exec;
   endproperty
   a_four_phases: assert property (p_four_phases) else $error("cycle not four clocks");
   // First cycle of the two-word move writes nothing.
   property p_ff_first;
      (in_exec && op_q == OP_FF1) |-> !dm_we;
   endproperty
   a_ff_first: assert property (p_ff_first) else $error("move wrote in first cycle");
   // Second cycle writes the byte read in the first and holds the flags.
   property p_ff_second;
      (q4 && op_q == OP_FF2) |-> (!dm_we || dm_wdata == move_q) ##1 $stable(flags_q);
   endproperty
   a_ff_second: assert property (p_ff_second) else $error("move data or flags wrong");
   // No-operation touches no data memory.
   property p_nop;
      (in_exec && op_q == OP_NOP) |-> !dm_we && !dm_re;
   endproperty
   a_nop: assert property (p_nop) else $error("no-operation accessed memory");
   // Negate writes the two's complement of the byte read.
   property p_neg;
      (q4 && op_q == OP_NEG) |-> dm_we && dm_wdata == 8'((~$past(dm_rdata)) + 8'h01);
   endproperty
   a_neg: assert property (p_neg) else $error("negate result wrong");
   // Pointer load second cycle writes the low byte.
   property p_pointer_load_low;
      (q4 && op_q == OP_LF2 && fsr_idx == 2'h2) |=> fsr_q[2][7:0] == $past(w2_q[7:0]);
   endproperty
   a_pointer_load_low: assert property (p_pointer_load_low) else $error("pointer low byte wrong");
endmodule

// ==== test/data_mem_model.sv ====
`timescale 1ns/1ns
// Byte-wide data memory that returns read data one clock after the strobe.
module data_mem_model (
   input wire logic hclk, // Core clock.
   input wire logic [11:0] dm_addr, // Address.
   input wire logic dm_re, // Read strobe.
   input wire logic dm_we, // Write strobe.
   input wire logic [7:0] dm_wdata, // Write data.
   output logic [7:0] dm_rdata // Read data.
);
   logic [7:0] mem [0:4095];
   logic [7:0] rd_q;
   logic vld_q;
   // Reads and writes happen on the strobe edge.
   always @(posedge hclk) begin
      vld_q <= dm_re;
      if (dm_re) begin
         rd_q <= mem[dm_addr];
      end
      if (dm_we) begin
         mem[dm_addr] <= dm_wdata;
      end
   end
   // Stale data shows inverted, so a late sample never matches.
   assign dm_rdata = vld_q ? rd_q : ~rd_q;
endmodule

// ==== test/byte_move_multiply_exec_test.sv ====
`timescale 1ns/1ns
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin err_count++; \
   $display("ERROR %s exp %h got %h", n, e, g); end end
module byte_move_multiply_exec_test
   import exec_pkg::*;
;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, dm_re, dm_we;
   logic [31:0] haddr, hwdata, hrdata, rv, c0;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [11:0] dm_addr;
   logic [7:0] dm_rdata, dm_wdata;
   int err_count = 0;
   int tests_run = 0;
   int cyc = 0;
   byte_move_multiply_exec byte_move_multiply_exec_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .dm_addr(dm_addr),
      .dm_re(dm_re), .dm_rdata(dm_rdata), .dm_we(dm_we), .dm_wdata(dm_wdata));
   data_mem_model data_mem_model_i (.hclk(hclk), .dm_addr(dm_addr), .dm_re(dm_re), .dm_we(dm_we),
      .dm_wdata(dm_wdata), .dm_rdata(dm_rdata));
   // Free-running clock at 50 ns.
   initial begin
      hclk = 1'b0;
      forever #25 hclk = ~hclk;
   end
   // Cuts a hung run short.
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         wrap_up();
      end
   end
   function automatic logic [7:0] m(input logic [11:0] a);
      return data_mem_model_i.mem[a];
   endfunction
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'b10;
      @(posedge hclk iff hreadyout === 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge hclk iff hreadyout === 1'b1);
      rv = hrdata;
   endtask
   task automatic chk(input logic [7:0] a, input logic [31:0] e, input string n);
      bus(a, 1'b0, 32'h0);
      `CHK(n, e, rv)
   endtask
   // Writes one instruction word and polls until the cycle finishes.
   task automatic ex(input logic [15:0] w);
      bus(OFS_INSTR, 1'b1, {16'h0, w});
      do bus(OFS_STAT, 1'b0, 32'h0); while (rv[STAT_BUSY_BIT] !== 1'b0);
   endtask
   task automatic t_reset();
      logic [7:0] ofs [7] = '{OFS_ACCUM, OFS_BANK, OFS_FLAGS, OFS_PROD, OFS_CTRL, OFS_FSR0, OFS_FSR2};
      foreach (ofs[i]) chk(ofs[i], 32'h0, "reset value");
      bus(8'h80, 1'b1, 32'hffffffff);
      chk(8'h80, 32'h0, "unmapped");
      `CHK("hresp okay", 1'b0, hresp)
   endtask
   task automatic t_lit();
      bus(OFS_FLAGS, 1'b1, 32'h15);
      ex(16'h0e5a);
      chk(OFS_ACCUM, 32'h5a, "accum");
      ex(16'h01f7);
      chk(OFS_BANK, 32'h07, "bank");
      chk(OFS_FLAGS, 32'h15, "flags");
   endtask
   task automatic t_mul();
      ex(16'h0ee2);
      ex(16'h0dc4);
      chk(OFS_PROD, 32'had08, "prod lit");
      bus(OFS_FLAGS, 1'b1, 32'h0);
      ex(16'h0d00);
      chk(OFS_PROD, 32'h0, "prod zero");
      chk(OFS_FLAGS, 32'h0, "zero not flagged");
      bus(OFS_FLAGS, 1'b1, 32'h15);
      data_mem_model_i.mem[12'h5b5] = 8'hb5;
      ex(16'h0ec4);
      ex(16'h0105);
      ex(16'h03b5);
      chk(OFS_PROD, 32'h8a94, "prod file");
      chk(OFS_ACCUM, 32'hc4, "accum kept");
      `CHK("file kept", 8'hb5, m(12'h5b5))
      chk(OFS_FLAGS, 32'h15, "flags");
   endtask
   task automatic t_store();
      ex(16'h0e4f);
      ex(16'h6f80);
      ex(16'h6fff);
      ex(16'h6e10);
      ex(16'h6ea0);
      `CHK("bank f", 8'h4f, m(12'h580))
      `CHK("bank top", 8'h4f, m(12'h5ff))
      `CHK("access lo", 8'h4f, m(12'h010))
      `CHK("access hi", 8'h4f, m(12'hfa0))
      chk(OFS_FLAGS, 32'h15, "flags");
   endtask
   task automatic t_move();
      data_mem_model_i.mem[12'h022] = 8'h22;
      data_mem_model_i.mem[12'h023] = 8'h80;
      ex(16'h5022);
      chk(OFS_ACCUM, 32'h22, "to accum");
      chk(OFS_FLAGS, 32'h01, "flags nz");
      ex(16'h5223);
      `CHK("to file", 8'h80, m(12'h023))
      chk(OFS_ACCUM, 32'h22, "accum kept");
      chk(OFS_FLAGS, 32'h11, "flags neg");
   endtask
   task automatic t_neg();
      logic [7:0] v [3] = '{8'h3a, 8'h00, 8'h80};
      logic [7:0] r [3] = '{8'hc6, 8'h00, 8'h80};
      logic [7:0] f [3] = '{8'h10, 8'h07, 8'h1a};
      foreach (v[i]) begin
         data_mem_model_i.mem[12'h030] = v[i];
         ex(16'h6c30);
         `CHK("negate", r[i], m(12'h030))
         chk(OFS_FLAGS, {24'h0, f[i]}, "neg flags");
      end
   endtask
   task automatic t_ff();
      bus(OFS_FLAGS, 1'b1, 32'h0a);
      data_mem_model_i.mem[12'habc] = 8'h33;
      bus(OFS_CYCLES, 1'b0, 32'h0);
      c0 = rv;
      ex(16'hcabc);
      `CHK("wait second", 32'h2, rv)
      ex(16'hf123);
      `CHK("ff copy", 8'h33, m(12'h123))
      chk(OFS_CYCLES, c0 + 32'd2, "ff cycles");
      ex(16'h0e77);
      ex(16'hcf00);
      ex(16'hffff);
      `CHK("ff from accum", 8'h77, m(12'hfff))
      ex(16'hc123);
      ex(16'hff00);
      chk(OFS_ACCUM, 32'h33, "ff to accum");
      chk(OFS_FLAGS, 32'h0a, "ff flags");
   endtask
   task automatic t_ptr();
      ex(16'hee23);
      ex(16'hf0ab);
      chk(OFS_FSR2, 32'h3ab, "pointer");
      chk(OFS_INSTR, 32'hf0abee23, "instr words");
      bus(OFS_CTRL, 1'b1, 32'h1);
      ex(16'h0e5c);
      ex(16'h6e05);
      ex(16'h6e60);
      `CHK("indexed", 8'h5c, m(12'h3b0))
      `CHK("above limit", 8'h5c, m(12'hf60))
      bus(OFS_CTRL, 1'b1, 32'h0);
   endtask
   task automatic t_nop();
      bus(OFS_CYCLES, 1'b0, 32'h0);
      c0 = rv;
      // The second word arrives while the first cycle runs, so it waits on the stall.
      bus(OFS_INSTR, 1'b1, 32'h0);
      ex(16'hf555);
      chk(OFS_CYCLES, c0 + 32'd2, "nop cycles");
      ex(16'h2800);
      `CHK("unsupported", 32'h4, rv)
      chk(OFS_ACCUM, 32'h5c, "nop accum");
      chk(OFS_FLAGS, 32'h0a, "nop flags");
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // Reset, then each scenario in turn.
   initial begin
      hresetn = 1'b0;
      hsel = 1'b1;
      hsize = 3'h2;
      htrans = 2'b00;
      hwrite = 1'b0;
      haddr = 32'h0;
      hwdata = 32'h0;
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_reset();
      t_lit();
      t_mul();
      t_store();
      t_move();
      t_neg();
      t_ff();
      t_ptr();
      t_nop();
      wrap_up();
   end
endmodule
